// ### design/gfx_draw_unit.sv
`timescale 1ns/1ps
`default_nettype none
module gfx_draw_unit
	import gfx_pkg::*;
#(
	parameter int FIFO_DEPTH = 8 // write buffer entries
) (
	input  wire logic                 clk_i,     // clock
	input  wire logic                 rst_i,     // sync reset
	// wishbone slave
	input  wire logic                 cyc_i,     // cycle
	input  wire logic                 stb_i,     // strobe
	input  wire logic                 we_i,      // write enable
	input  wire logic [7:0]           adr_i,     // byte address
	input  wire logic [3:0]           sel_i,     // byte enables
	input  wire logic [31:0]          dat_i,     // write data
	output logic      [31:0]          dat_o,     // read data
	output logic                      ack_o,     // acknowledge
	// pixel memory write stream
	output logic                      wr_valid_o, // write word valid
	input  wire logic                 wr_ready_i, // memory takes it
	output logic      [31:0]          wr_addr_o, // linear bit address
	output logic      [31:0]          wr_data_o, // pixel data
	output logic      [31:0]          wr_mask_o, // writable bits
	// pixel memory read
	output logic                      rd_req_o,  // read request
	output logic      [31:0]          rd_addr_o, // read address
	input  wire logic                 rd_ack_i,  // read done
	input  wire logic [31:0]          rd_data_i  // read pixel
);
	import gfx_pkg::*;
	// ********************************************
	// register map
	// ********************************************
	localparam logic [5:0] R_CMD = 6'h00, R_STAT = 6'h01, R_SRC = 6'h02, R_DST = 6'h03;
	localparam logic [5:0] R_SAD = 6'h04, R_DAD = 6'h05, R_DIM = 6'h06, R_WLO = 6'h07;
	localparam logic [5:0] R_WHI = 6'h08, R_COL = 6'h09, R_CNT = 6'h0A, R_IN1 = 6'h0B;
	localparam logic [5:0] R_IN2 = 6'h0C, R_PAT = 6'h0D, R_CTL = 6'h0E, R_PSZ = 6'h0F;
	localparam logic [5:0] R_PMK = 6'h10, R_PIT = 6'h11, R_OFS = 6'h12, R_RES = 6'h13;
	localparam logic [5:0] R_LAST = R_RES;
	// ********************************************
	// state
	// ********************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_RUN = 3'b001, S_RD = 3'b011, S_WR = 3'b010, S_DONE = 3'b110
	} state_t;
	state_t      st_q;               // sequencer state
	logic [31:0] src_q, dst_q;       // rs, rd operands
	logic [31:0] sad_q, dad_q, dim_q; // array start and dimensions
	logic [31:0] wlo_q, whi_q, col_q; // window limits, foreground_colour
	logic [31:0] cnt_q, in1_q, in2_q, pat_q; // line operands
	logic [31:0] ctl_q, pit_q, ofs_q, res_q; // control, pitch, offset, result
	logic [5:0]  psz_q;              // pixel_width_setting
	logic [31:0] pmk_q;              // plane_protect_mask
	logic [15:0] cmd_q;              // latched command word
	logic [1:0]  err_q;              // last error
	logic [15:0] x_q, y_q, cx_q, cy_q; // walk position, column and row counts
	logic [31:0] pix_q;              // pixel fetched
	logic signed [31:0] dd_q;        // bresenham decision
	logic        ack_q;              // bus answer
	// ********************************************
	// command fields
	// ********************************************
	opcode_t     op;                 // opcode
	logic        lsel;               // line variant, 0 if absent
	logic [1:0]  sk, dk;             // source and destination kinds
	assign op   = opcode_t'(cmd_q[3:0]);
	assign lsel = cmd_q[4];
	assign sk   = cmd_q[6:5];
	assign dk   = cmd_q[8:7];
	// ********************************************
	// address helpers
	// ********************************************
	function automatic logic [31:0] xy_lin(input logic [31:0] xy);
		// linear = offset + y*pitch + x*pixel_width_setting
		xy_lin = ofs_q + 32'(xy[31:16] * pit_q[15:0]) + 32'(xy[15:0] * psz_q);
	endfunction : xy_lin
	function automatic logic [31:0] plane_protect_mask(input logic [5:0] w);
		plane_protect_mask = (w >= 6'h20) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
	endfunction : plane_protect_mask
	function automatic logic [31:0] pp_apply(input logic [31:0] s, input logic [31:0] d);
		unique case (ctl_q[CTL_PP0 +: CTL_PPW])
			PP_REPL: pp_apply = s;
			PP_AND:  pp_apply = s & d;
			PP_OR:   pp_apply = s | d;
			PP_XOR:  pp_apply = s ^ d;
		endcase
	endfunction : pp_apply
	logic [15:0] px, py;             // current pixel xy
	logic        inwin;              // current pixel in window
	assign px    = x_q;
	assign py    = y_q;
	assign inwin = !(ctl_q[CTL_W]) || (px >= wlo_q[15:0] && px <= whi_q[15:0]
		&& py >= wlo_q[31:16] && py <= whi_q[31:16]);
	// ********************************************
	// write buffer between sequencer and memory
	// ********************************************
	logic        fq_valid, fq_ready; // sequencer side handshake
	logic [31:0] fq_addr, fq_data;   // sequencer words
	logic [95:0] fq_out;             // buffered word
	gfx_fifo #(.WIDTH(96), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.in_valid_i (fq_valid),
		.in_ready_o (fq_ready),
		.in_data_i  ({fq_addr, fq_data, plane_protect_mask(psz_q) & ~pmk_q}),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o (fq_out),
		.full_o     (),
		.empty_o    ()
	);
	assign wr_addr_o = fq_out[95:64];
	assign wr_data_o = fq_out[63:32];
	assign wr_mask_o = fq_out[31:0];
	// ********************************************
	// wishbone slave, one wait state
	// ********************************************
	logic [5:0] ridx;                // word index
	logic       bus_go, busy;        // new access, unit busy
	assign ridx   = adr_i[7:2];
	assign bus_go = cyc_i && stb_i && !ack_q;
	assign busy   = (st_q != S_IDLE);
	assign ack_o  = ack_q;
	// ack one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) ack_q <= 1'b0;
		else ack_q <= bus_go;
	end
	// read mux, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) dat_o <= 32'h0;
		else if (bus_go && !we_i) begin
			unique case (ridx)
				R_CMD:  dat_o <= {16'h0, cmd_q};
				R_STAT: dat_o <= {29'h0, err_q, busy};
				R_SRC:  dat_o <= src_q;
				R_DST:  dat_o <= dst_q;
				R_SAD:  dat_o <= sad_q;
				R_DAD:  dat_o <= dad_q;
				R_DIM:  dat_o <= dim_q;
				R_WLO:  dat_o <= wlo_q;
				R_WHI:  dat_o <= whi_q;
				R_COL:  dat_o <= col_q;
				R_CNT:  dat_o <= cnt_q;
				R_IN1:  dat_o <= in1_q;
				R_IN2:  dat_o <= in2_q;
				R_PAT:  dat_o <= pat_q;
				R_CTL:  dat_o <= ctl_q;
				R_PSZ:  dat_o <= {26'h0, psz_q};
				R_PMK:  dat_o <= pmk_q;
				R_PIT:  dat_o <= pit_q;
				R_OFS:  dat_o <= ofs_q;
				R_RES:  dat_o <= res_q;
				default: dat_o <= 32'h0;
			endcase
		end
	end
	logic wr_en;                     // software write
	assign wr_en = bus_go && we_i && (sel_i == 4'hF) && !busy;
	// ********************************************
	// operand registers and sequencer
	// ********************************************
	assign rd_req_o  = (st_q == S_RD);
	assign rd_addr_o = (sk == AK_XY) ? xy_lin(src_q) : src_q;
	// main sequencer: operands change only while idle or by the instruction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= S_IDLE; cmd_q <= 16'h0; err_q <= ER_NONE;
			src_q <= 32'h0; dst_q <= 32'h0; sad_q <= 32'h0; dad_q <= 32'h0;
			dim_q <= 32'h0; wlo_q <= 32'h0; whi_q <= 32'h0; col_q <= 32'h0;
			cnt_q <= 32'h0; in1_q <= 32'h0; in2_q <= 32'h0; pat_q <= 32'h0;
			ctl_q <= 32'h0; psz_q <= PIXEL_WIDTH_SETTING_RST; pmk_q <= 32'h0; pit_q <= 32'h0;
			ofs_q <= 32'h0; res_q <= 32'h0; x_q <= 16'h0; y_q <= 16'h0;
			cx_q <= 16'h0; cy_q <= 16'h0; pix_q <= 32'h0; dd_q <= 32'sh0;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (wr_en) begin
						unique case (ridx)
							R_SRC: src_q <= dat_i;
							R_DST: dst_q <= dat_i;
							R_SAD: sad_q <= dat_i;
							R_DAD: dad_q <= dat_i;
							R_DIM: dim_q <= dat_i;
							R_WLO: wlo_q <= dat_i;
							R_WHI: whi_q <= dat_i;
							R_COL: col_q <= dat_i;
							R_CNT: cnt_q <= dat_i;
							R_IN1: in1_q <= dat_i;
							R_IN2: in2_q <= dat_i;
							R_PAT: pat_q <= dat_i;
							R_CTL: ctl_q <= dat_i;
							R_PSZ: psz_q <= dat_i[5:0];
							R_PMK: pmk_q <= dat_i;
							R_PIT: pit_q <= dat_i;
							R_OFS: ofs_q <= dat_i;
							R_CMD: begin
								cmd_q <= dat_i[15:0];
								err_q <= ER_NONE;
								st_q  <= S_RUN;
							end
							default: ;
						endcase
					end
				end
				S_RUN: begin
					st_q <= S_DONE;
					unique case (op)
						OP_CPW: begin
							res_q <= 32'h0;
							res_q[WC_HI:WC_LO] <=
								((src_q[15:0] < wlo_q[15:0]) ? WC_LEFT : 4'h0) |
								((src_q[15:0] > whi_q[15:0]) ? WC_RIGHT : 4'h0) |
								((src_q[31:16] < wlo_q[31:16]) ? WC_ABOVE : 4'h0) |
								((src_q[31:16] > whi_q[31:16]) ? WC_BELOW : 4'h0);
						end
						OP_CVT: dst_q <= xy_lin(src_q);
						OP_DRAW: begin
							x_q <= dst_q[15:0]; y_q <= dst_q[31:16];
							cx_q <= 16'h1; cy_q <= 16'h1; st_q <= S_WR;
						end
						OP_LINE: begin
							x_q <= dad_q[15:0]; y_q <= dad_q[31:16];
							dd_q <= $signed(src_q); cx_q <= cnt_q[15:0]; cy_q <= 16'h1;
							st_q <= (cnt_q[15:0] == 16'h0) ? S_DONE : S_WR;
						end
						OP_FILL, OP_BLT: begin
							if (op == OP_BLT && sk == AK_XY && dk != AK_XY) begin
								err_q <= ER_FORM;
							end else begin
								x_q <= dad_q[15:0]; y_q <= dad_q[31:16];
								cx_q <= dim_q[15:0]; cy_q <= dim_q[31:16];
								if (ctl_q[CTL_W] && dk == AK_XY) begin
									x_q <= (dad_q[15:0] < wlo_q[15:0]) ? wlo_q[15:0] : dad_q[15:0];
									y_q <= (dad_q[31:16] < wlo_q[31:16]) ? wlo_q[31:16] : dad_q[31:16];
									dad_q <= {(dad_q[31:16] < wlo_q[31:16]) ? wlo_q[31:16] : dad_q[31:16],
										(dad_q[15:0] < wlo_q[15:0]) ? wlo_q[15:0] : dad_q[15:0]};
								end
								if (dim_q[15:0] != 16'h0 && dim_q[31:16] != 16'h0)
									st_q <= (op == OP_BLT) ? S_RD : S_WR;
							end
						end
						OP_SINGLE_PIXEL_TRANSFER: begin
							if (sk == PT_REG && dk == PT_REG) err_q <= ER_FORM;
							else if (sk == PT_REG) begin
								pix_q <= src_q; st_q <= S_WR;
							end else st_q <= S_RD;
							x_q <= dst_q[15:0]; y_q <= dst_q[31:16];
							cx_q <= 16'h1; cy_q <= 16'h1;
						end
						default: err_q <= ER_OP;
					endcase
				end
				S_RD: begin
					if (rd_ack_i) begin
						pix_q <= rd_data_i;
						if (op == OP_SINGLE_PIXEL_TRANSFER && dk == PT_REG) begin
							dst_q <= rd_data_i & plane_protect_mask(psz_q);
							st_q  <= S_DONE;
						end else st_q <= S_WR;
					end
				end
				S_WR: begin
					if (fq_ready || !inwin) begin
						unique case (op)
							OP_DRAW: begin
								dst_q <= {dst_q[31:16] + src_q[31:16], dst_q[15:0] + src_q[15:0]};
								st_q  <= S_DONE;
							end
							OP_SINGLE_PIXEL_TRANSFER: st_q <= S_DONE;
							OP_LINE: begin
								pat_q <= {pat_q[0], pat_q[31:1]};
								if (lsel ? (dd_q > 32'sh0) : (dd_q >= 32'sh0)) begin
									x_q <= x_q + in2_q[15:0]; y_q <= y_q + in2_q[31:16];
									dd_q <= dd_q + $signed(in2_q[15:0]) - $signed(in1_q[15:0]);
								end else begin
									x_q <= x_q + in1_q[15:0]; y_q <= y_q + in1_q[31:16];
									dd_q <= dd_q + $signed({16'h0, in1_q[15:0]});
								end
								cx_q <= cx_q - 16'h1;
								if (cx_q == 16'h1) st_q <= S_DONE;
							end
							default: begin
								if (cx_q != 16'h1) begin
									cx_q <= cx_q - 16'h1;
									x_q  <= ctl_q[CTL_PBH] ? x_q - 16'h1 : x_q + 16'h1;
									src_q <= src_q + 32'(psz_q);
									st_q <= (op == OP_BLT) ? S_RD : S_WR;
								end else if (cy_q != 16'h1) begin
									cx_q <= dim_q[15:0]; cy_q <= cy_q - 16'h1;
									x_q  <= dad_q[15:0];
									y_q  <= ctl_q[CTL_PBV] ? y_q - 16'h1 : y_q + 16'h1;
									src_q <= src_q + 32'(psz_q);
									st_q <= (op == OP_BLT) ? S_RD : S_WR;
								end else st_q <= S_DONE;
							end
						endcase
					end
				end
				S_DONE: st_q <= S_IDLE;
				default: st_q <= S_IDLE;
			endcase
		end
	end
	// ********************************************
	// pixel write generation
	// ********************************************
	logic [31:0] spix;               // source pixel value
	logic        skip_t;             // transparent zero pixel
	assign spix    = (op == OP_BLT || op == OP_SINGLE_PIXEL_TRANSFER) ? pix_q : col_q;
	assign skip_t  = ctl_q[CTL_T] && ((spix & plane_protect_mask(psz_q)) == 32'h0);
	assign fq_valid = (st_q == S_WR) && inwin && !skip_t
		&& !(op == OP_LINE && !pat_q[0]);
	logic [15:0] dx_off, dy_off;     // walk offset from array start
	assign dx_off  = x_q - dad_q[15:0];
	assign dy_off  = y_q - dad_q[31:16];
	// xy walks leave as linear words; linear arrays step by pixel width and pitch
	assign fq_addr = (op == OP_SINGLE_PIXEL_TRANSFER && dk != AK_XY) ? dst_q
		: ((op == OP_FILL || op == OP_BLT) && dk != AK_XY)
		? dad_q + 32'(dx_off * psz_q) + 32'(dy_off * pit_q[15:0]) : xy_lin({y_q, x_q});
	assign fq_data = pp_apply(spix, 32'h0);
endmodule : gfx_draw_unit
`default_nettype wire

// ### design/gfx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module gfx_fifo #(
	parameter int WIDTH = 64, // word width
	parameter int DEPTH = 8   // entries
) (
	input  wire logic             clk_i,     // clock
	input  wire logic             rst_i,     // sync reset
	input  wire logic             in_valid_i, // write request
	output logic                  in_ready_o, // space free
	input  wire logic [WIDTH-1:0] in_data_i, // write word
	output logic                  out_valid_o, // word held
	input  wire logic             out_ready_i, // drain
	output logic      [WIDTH-1:0] out_data_o, // head word
	output logic                  full_o,    // full flag
	output logic                  empty_o    // empty flag
);
	localparam int AW = $clog2(DEPTH); // pointer width
	// refused at elaboration: wrap-bit pointers need a power of two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("depth must be power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH]; // storage
	logic [AW:0]      wp_q;          // write pointer with wrap bit
	logic [AW:0]      rp_q;          // read pointer with wrap bit
	logic             push, pop;     // accepted moves
	assign empty_o     = (wp_q == rp_q);
	assign full_o      = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
	assign in_ready_o  = !full_o;
	assign out_valid_o = !empty_o;
	assign push        = in_valid_i && !full_o;
	assign pop         = out_ready_i && !empty_o;
	assign out_data_o  = mem_q[rp_q[AW-1:0]];
	// storage write, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data_i;
		end
	end
	// pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (pop) rp_q <= rp_q + 1'b1;
		end
	end
endmodule : gfx_fifo
`default_nettype wire

// ### design/gfx_pkg.sv
package gfx_pkg;
	// ********************************************
	// opcodes
	// ********************************************
	typedef enum logic [3:0] {
		OP_CPW   = 4'h0, // point window compare
		OP_CVT   = 4'h1, // xy to linear
		OP_DRAW  = 4'h2, // draw and advance
		OP_LINE  = 4'h3, // line inner loop
		OP_FILL  = 4'h4, // fill rectangle
		OP_SINGLE_PIXEL_TRANSFER  = 4'h5, // single pixel move
		OP_BLT   = 4'h6  // block move
	} opcode_t;
	// ********************************************
	// address kinds and pixel transfer forms
	// ********************************************
	localparam logic [1:0] AK_BIN = 2'h0; // binary source
	localparam logic [1:0] AK_LIN = 2'h1; // linear
	localparam logic [1:0] AK_XY  = 2'h2; // xy
	localparam logic [1:0] PT_REG = 2'h3; // register operand (pixel move)
	// ********************************************
	// control bit positions
	// ********************************************
	localparam int CTL_W   = 0; // window hit enable
	localparam int CTL_T   = 1; // transparency
	localparam int CTL_PBH = 2; // horizontal_block_direction
	localparam int CTL_PBV = 3; // vertical_block_direction
	localparam int CTL_PP0 = 4; // pixel_processing_op low bit
	localparam int CTL_PPW = 2; // pixel_processing_op width
	// window code field
	localparam int WC_LO = 5; // code low bit
	localparam int WC_HI = 8; // code high bit
	localparam logic [3:0] WC_LEFT  = 4'h1; // x below lower limit
	localparam logic [3:0] WC_RIGHT = 4'h2; // x above upper limit
	localparam logic [3:0] WC_ABOVE = 4'h4; // y below lower limit
	localparam logic [3:0] WC_BELOW = 4'h8; // y above upper limit
	// error codes
	localparam logic [1:0] ER_NONE = 2'h0; // ok
	localparam logic [1:0] ER_FORM = 2'h1; // illegal operand form
	localparam logic [1:0] ER_OP   = 2'h2; // unknown opcode
	// pixel op codes
	localparam logic [1:0] PP_REPL = 2'h0; // replace
	localparam logic [1:0] PP_AND  = 2'h1; // and
	localparam logic [1:0] PP_OR   = 2'h2; // or
	localparam logic [1:0] PP_XOR  = 2'h3; // xor
	localparam logic [5:0] PIXEL_WIDTH_SETTING_RST = 6'h10; // pixel width after reset
endpackage : gfx_pkg

// ### test/gfx_draw_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gfx_draw_unit_checker (
	input wire logic        clk_i,      // clock
	input wire logic        rst_i,      // sync reset
	input wire logic        cyc_i,      // bus cycle
	input wire logic        stb_i,      // strobe
	input wire logic        we_i,       // direction
	input wire logic [31:0] dat_o,      // read data
	input wire logic        ack_o,      // acknowledge
	input wire logic        wr_valid_o, // write offered
	input wire logic        wr_ready_i, // write taken
	input wire logic [31:0] wr_addr_o,  // write address
	input wire logic [31:0] wr_data_o,  // write data
	input wire logic [31:0] wr_mask_o,  // write mask
	input wire logic        rd_req_o,   // read request
	input wire logic [31:0] rd_addr_o,  // read address
	input wire logic        rd_ack_i    // read answer
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ********************************
	// register bus answer
	// ********************************
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack not one cycle after request");
	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> cyc_i && stb_i && $past(cyc_i && stb_i))
		else $error("ack without request");
	read_hold_a: assert property (!(cyc_i && stb_i && !we_i) |=> $stable(dat_o))
		else $error("read data moved without a read");
	reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !wr_valid_o && !rd_req_o)
		else $error("outputs active after reset");
	// ********************************
	// pixel memory handshakes
	// ********************************
	wr_keep_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o)
		else $error("write word withdrawn");
	wr_stable_a: assert property (wr_valid_o && !wr_ready_i |=>
		$stable(wr_addr_o) && $stable(wr_data_o) && $stable(wr_mask_o))
		else $error("write word changed while stalled");
	rd_keep_a: assert property (rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_addr_o))
		else $error("read request dropped or moved");
endmodule : gfx_draw_unit_checker
bind gfx_draw_unit gfx_draw_unit_checker chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .wr_valid_o(wr_valid_o),
	.wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_mask_o(wr_mask_o),
	.rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_ack_i(rd_ack_i));
`default_nettype wire

// ### test/gfx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module gfx_mem_model (
	input  wire logic        clk_i,      // clock
	input  wire logic        rst_i,      // sync reset
	input  wire logic        stall_i,    // hold off writes
	input  wire logic        wr_valid_i, // write offered
	output logic             wr_ready_o, // write taken
	input  wire logic [31:0] wr_addr_i,  // write address
	input  wire logic [31:0] wr_data_i,  // write data
	input  wire logic [31:0] wr_mask_i,  // write mask
	input  wire logic        rd_req_i,   // read request
	input  wire logic [31:0] rd_addr_i,  // read address
	output logic             rd_ack_o,   // read done pulse
	output logic [31:0]      rd_data_o   // read data
);
	int          wr_count;     // words taken
	int          rd_count;     // reads answered
	logic [31:0] last_addr;    // last write address
	logic [31:0] last_data;    // last write data
	logic [31:0] last_mask;    // last write mask
	logic [31:0] last_rd_addr; // last read address
	logic [1:0]  wait_q;       // read latency count
	assign wr_ready_o = !stall_i;
	// ********************************
	// write side: record each word taken
	// ********************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_count <= 0;
		end else if (wr_valid_i && wr_ready_o) begin
			wr_count  <= wr_count + 1;
			last_addr <= wr_addr_i;
			last_data <= wr_data_i;
			last_mask <= wr_mask_i;
		end
	end
	// ********************************
	// read side: slow answer; bus toggles when idle so stale data never looks valid
	// ********************************
	always_ff @(posedge clk_i) begin
		if (rst_i || !rd_req_i || rd_ack_o) begin
			rd_ack_o  <= 1'b0;
			wait_q    <= 2'h0;
			rd_data_o <= rst_i ? 32'hA5A5_A5A5 : ~rd_data_o;
			rd_count  <= rst_i ? 0 : rd_count;
		end else if (wait_q == 2'h2) begin
			rd_ack_o     <= 1'b1;
			rd_data_o    <= rd_addr_i ^ 32'h5A5A_0000;
			rd_count     <= rd_count + 1;
			last_rd_addr <= rd_addr_i;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule : gfx_mem_model
`default_nettype wire

// ### test/tb_graphics_draw_instruction_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_graphics_draw_instruction_unit;
	import gfx_pkg::*;
	typedef struct {logic [31:0] cmd; logic [31:0] src; logic [7:0] adr; logic [31:0] msk; logic [31:0] exp;} row_t;
	logic        clk_i = 1'b0;  // clock
	logic        rst_i = 1'b1;  // sync reset
	logic        cyc   = 1'b0;  // bus cycle
	logic        stb   = 1'b0;  // strobe
	logic        we    = 1'b0;  // direction
	logic [7:0]  adr   = 8'h00; // address
	logic [31:0] dat_w = 32'h0; // write data
	logic        stall = 1'b0;  // memory holds off
	logic        ack, wr_valid, wr_ready, rd_req, rd_ack;
	logic [31:0] dat_rd, wr_addr, wr_data, wr_mask, rd_addr, rd_data, v;
	int          err_total = 0;  // mismatches
	int          n_compared = 0; // comparisons
	int          ticks = 0;      // cycle count
	int          base;           // count before an operation
	// point compare rows then conversion row
	row_t rows [6] = '{
		'{32'h0000_0140, 32'h000F_000F, 8'h4C, 32'h0000_01E0, 32'h0000_0000},
		'{32'h0000_0140, 32'h000F_0005, 8'h4C, 32'h0000_01E0, 32'h0000_0020},
		'{32'h0000_0140, 32'h000F_0019, 8'h4C, 32'h0000_01E0, 32'h0000_0040},
		'{32'h0000_0140, 32'h0005_000F, 8'h4C, 32'h0000_01E0, 32'h0000_0080},
		'{32'h0000_0140, 32'h0019_000F, 8'h4C, 32'h0000_01E0, 32'h0000_0100},
		'{32'h0000_0141, 32'h0003_0002, 8'h0C, 32'hFFFF_FFFF, 32'h0000_3120}};
	logic [31:0] bad_cmd [4] = '{32'h0000_01E5, 32'h0000_00C6, 32'h0000_0007, 32'h0000_000F};
	logic [1:0]  bad_err [4] = '{ER_FORM, ER_FORM, ER_OP, ER_OP};
	logic [31:0] pt_src [2] = '{32'h0000_2000, 32'h0001_0001};
	logic [31:0] pt_cmd [2] = '{32'h0000_01A5, 32'h0000_01C5};
	logic [31:0] pt_adr [2] = '{32'h0000_2000, 32'h0000_1110};
	always #4 clk_i = ~clk_i;
	gfx_draw_unit dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_rd), .ack_o(ack), .wr_valid_o(wr_valid),
		.wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_mask_o(wr_mask),
		.rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_data_i(rd_data));
	gfx_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .wr_valid_i(wr_valid),
		.wr_ready_o(wr_ready), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_mask_i(wr_mask),
		.rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_ack_o(rd_ack), .rd_data_o(rd_data));
	// ********************************
	// helpers
	// ********************************
	task automatic results;
		if (err_total == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// one classic cycle; held until ack, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		q = dat_rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, 8'h04, 32'h0, v);
			n++;
		end while (v[0] !== 1'b0 && n < 300);
		if (n >= 300) err_total++;
	endtask : wait_idle
	task automatic wait_mem(input int want);
		int n;
		n = 0;
		while (mem.wr_count < want && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 500) err_total++;
	endtask : wait_mem
	// hang guard
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 40000) begin
			err_total++;
			results();
		end
	end
	// ********************************
	// main sequence
	// ********************************
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, 8'h3C, 32'h0, v);
		chk(v, {26'h0, PIXEL_WIDTH_SETTING_RST}, "pixel width reset");
		wr(8'h1C, 32'h000A_000A);
		wr(8'h20, 32'h0014_0014);
		wr(8'h44, 32'h0000_1000);
		wr(8'h48, 32'h0000_0100);
		for (int i = 0; i < 6; i++) begin
			wr(8'h08, rows[i].src);
			wr(8'h00, rows[i].cmd);
			wait_idle();
			bus(1'b0, rows[i].adr, 32'h0, v);
			chk(v & rows[i].msk, rows[i].exp, "table row");
		end
		// draw at x edge: x half wraps without carrying into y
		wr(8'h24, 32'hABCD_ABCD);
		wr(8'h0C, 32'h0004_FFFF);
		wr(8'h08, 32'h0001_0002);
		wr(8'h40, 32'h0000_0000);
		base = mem.wr_count;
		wr(8'h00, 32'h0000_0142);
		wait_idle();
		wait_mem(base + 1);
		chk(mem.last_addr, 32'h0010_40F0, "draw address");
		chk(mem.last_data & 32'h0000_FFFF, 32'h0000_ABCD, "draw colour");
		chk(32'($countones(mem.last_mask)), 32'h10, "pixel mask width");
		bus(1'b0, 8'h0C, 32'h0, v);
		chk(v, 32'h0005_0001, "advance halves");
		// xy fill of 12 pixels against a stalled memory fills the buffer and holds the sequencer
		stall <= 1'b1;
		wr(8'h14, 32'h0002_0001);
		wr(8'h18, 32'h0003_0004);
		base = mem.wr_count;
		wr(8'h00, 32'h0000_0104);
		repeat (40) @(posedge clk_i);
		chk({31'h0, wr_valid}, 32'h1, "stalled word held");
		wr(8'h24, 32'h0000_1111);
		stall <= 1'b0;
		wait_idle();
		wait_mem(base + 12);
		chk(32'(mem.wr_count - base), 32'hC, "fill count");
		chk(mem.last_addr, 32'h0000_4140, "fill last pixel");
		bus(1'b0, 8'h24, 32'h0, v);
		chk(v, 32'hABCD_ABCD, "busy write dropped");
		// linear form of fill
		wr(8'h14, 32'h0000_8000);
		wr(8'h18, 32'h0001_0002);
		base = mem.wr_count;
		wr(8'h00, 32'h0000_0084);
		wait_idle();
		wait_mem(base + 2);
		chk(mem.last_addr, 32'h0000_8010, "linear fill");
		// refused forms and opcodes write nothing
		for (int i = 0; i < 4; i++) begin
			base = mem.wr_count;
			wr(8'h00, bad_cmd[i]);
			wait_idle();
			chk({30'h0, v[2:1]}, {30'h0, bad_err[i]}, "error code");
			chk(32'(mem.wr_count - base), 32'h0, "no write on error");
		end
		// pixel read from linear and from xy addresses
		for (int i = 0; i < 2; i++) begin
			base = mem.rd_count;
			wr(8'h08, pt_src[i]);
			wr(8'h00, pt_cmd[i]);
			wait_idle();
			chk(32'(mem.rd_count - base), 32'h1, "one pixel read");
			chk(mem.last_rd_addr, pt_adr[i], "pixel read address");
			bus(1'b0, 8'h0C, 32'h0, v);
			chk(v, (pt_adr[i] ^ 32'h5A5A_0000) & 32'h0000_FFFF, "pixel into register");
		end
		// line of three pixels; the variant bit decides the tie step before the last
		wr(8'h14, 32'h0001_0001);
		wr(8'h28, 32'h0000_0003);
		wr(8'h2C, 32'h0000_0001);
		wr(8'h30, 32'h0001_0001);
		wr(8'h34, 32'hFFFF_FFFF);
		for (int i = 0; i < 2; i++) begin
			wr(8'h08, 32'hFFFF_FFFF);
			base = mem.wr_count;
			wr(8'h00, i ? 32'h0000_0013 : 32'h0000_0003);
			wait_idle();
			wait_mem(base + 3);
			chk(32'(mem.wr_count - base), 32'h3, "line pixels");
			chk(mem.last_addr, i ? 32'h0000_1130 : 32'h0000_2130, "line end");
		end
		results();
	end
endmodule : tb_graphics_draw_instruction_unit
`default_nettype wire
